// ===== core/epms_pkg.sv
// Package for the external program memory strobe block.
// Assumes a single core clock with synchronous active-high reset.
package epms_pkg;

    // Widths
    localparam int ADDR_W  = 16;
    localparam int DATA_W  = 8;

    // Reset values of the strobes (all negated, high)
    localparam logic RST_STROBE_N = 1'b1;
    localparam logic RST_SELECT_N = 1'b1;

    // Strobe width in core cycles for one access
    localparam int STROBE_CYC = 2;
    localparam int CNT_W      = 4;

    // Access sequencer states
    typedef enum logic [1:0] {
        EPMS_IDLE  = 2'b00,
        EPMS_READ  = 2'b01,
        EPMS_WRITE = 2'b10,
        EPMS_DONE  = 2'b11
    } epms_state_t;

endpackage : epms_pkg

// ===== core/epms_sleep_gate.sv
// Decides when the code memory may be released during sleep.
// Assumes the three power inputs are synchronous to clk.
`timescale 1ns/1ps
module epms_sleep_gate
    import epms_pkg::*;
(
    input  wire logic clk,                // Core clock
    input  wire logic rst,                // Synchronous reset, active high
    input  wire logic power_ctrl_bit0,    // Core idle flag
    input  wire logic wake_interrupt_two, // Wake interrupt, active high
    input  wire logic sleep_select,       // Sleep select bit
    output logic      release_ok          // Registered: chip enable may drop
);
    logic next_release_ok;

    // All three must hold; any one failing re-selects the memory
    always_comb begin
        next_release_ok = power_ctrl_bit0 && !wake_interrupt_two && sleep_select;
        if (rst) begin
            next_release_ok = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        release_ok <= next_release_ok;
    end
endmodule : epms_sleep_gate

// ===== core/epms_top.sv
// Strobe sequencer for the external code memory interface.
// Assumes the core issues one-cycle access requests with address and data,
// and that the external memory is fully static (no wait handshake).
`timescale 1ns/1ps
// Notes on behaviour
// - Write strobe goes low to write code memory, high otherwise.
// - Read strobe goes low to read code memory, high otherwise.
// - Chip select is active low; low selects the code memory.
// - Select released only when idle set, wake negated, sleep select set.
// - During reset the chip select is held high.
// - Address presented on the address outputs for the whole access.
module epms_top
    import epms_pkg::*;
#(
    parameter int STROBE_CYCLES = STROBE_CYC
)(
    input  wire logic              clk,                     // Core clock, 20 MHz
    input  wire logic              rst,                     // Synchronous reset, active high
    input  wire logic              power_ctrl_bit0,         // Core idle flag
    input  wire logic              wake_interrupt_two,      // Wake interrupt
    input  wire logic              sleep_select,            // Sleep select bit
    input  wire logic              req_valid,               // One-cycle access request
    input  wire logic              req_write,               // 1 write, 0 read
    input  wire logic [ADDR_W-1:0] req_addr,                // Access address
    input  wire logic [DATA_W-1:0] req_wdata,               // Write data
    input  wire logic [DATA_W-1:0] code_mem_data_in,        // Data bus from memory
    output logic                   req_busy,                // Access in progress
    output logic                   rsp_valid,               // One-cycle completion pulse
    output logic [DATA_W-1:0]      rsp_rdata,               // Read data
    output logic [ADDR_W-1:0]      code_mem_addr,           // Address outputs
    output logic [DATA_W-1:0]      code_mem_data_out,       // Data bus to memory
    output logic                   code_mem_data_oe,        // Data bus drive enable
    output logic                   code_mem_write_strobe_n, // Write strobe
    output logic                   code_mem_read_strobe_n,  // Read strobe
    output logic                   code_mem_select_n        // Chip select
);
    // Refuse strobe widths that the down-counter cannot hold
    if (STROBE_CYCLES < 1 || STROBE_CYCLES >= (1 << CNT_W)) begin : g_bad_strobe_width
        $error("STROBE_CYCLES out of range");
    end

    logic              release_ok;   // Registered sleep release from the gate
    logic              take;         // Request accepted at this edge
    epms_state_t       state;        // Access sequencer state
    epms_state_t       next_state;
    logic [CNT_W-1:0]  cnt;          // Strobe cycles still to run after this one
    logic [CNT_W-1:0]  next_cnt;
    logic              next_busy;
    logic              next_rsp;
    logic              next_wr_n;
    logic              next_rd_n;
    logic [ADDR_W-1:0] next_addr;
    logic [DATA_W-1:0] next_wdata;
    logic [DATA_W-1:0] next_rdata;
    logic              next_oe;
    logic              next_sel_n;

    // A request counts only from idle and only while the memory stays selected
    function automatic logic take_req(input logic        valid,
                                      input logic        released,
                                      input epms_state_t cur);
        return valid && !released && (cur == EPMS_IDLE);
    endfunction : take_req

    // Last strobe cycle is reached when the down-counter sits at zero
    function automatic logic last_beat(input logic [CNT_W-1:0] count);
        return (count == '0);
    endfunction : last_beat

    // Requests while released are dropped, not queued: the core must retry
    assign take = take_req(req_valid, release_ok, state);

    epms_sleep_gate u_gate (
        .clk                (clk),
        .rst                (rst),
        .power_ctrl_bit0    (power_ctrl_bit0),
        .wake_interrupt_two (wake_interrupt_two),
        .sleep_select       (sleep_select),
        .release_ok         (release_ok)
    );

    // Sequencer: one access at a time, strobe phase of STROBE_CYCLES cycles
    always_comb begin
        next_state = state;
        next_cnt   = cnt;
        next_rsp   = 1'b0;
        case (state)
            EPMS_IDLE: begin
                if (take) begin
                    next_cnt = CNT_W'(STROBE_CYCLES - 1);
                    if (req_write) begin
                        next_state = EPMS_WRITE;
                    end else begin
                        next_state = EPMS_READ;
                    end
                end
            end
            EPMS_READ, EPMS_WRITE: begin
                if (last_beat(cnt)) begin
                    next_state = EPMS_DONE;
                    next_rsp   = 1'b1;
                end else begin
                    next_cnt = cnt - 1'b1;
                end
            end
            EPMS_DONE: begin
                // Turnaround cycle keeps write data driven past the strobe edge
                next_state = EPMS_IDLE;
            end
            default: begin
                next_state = EPMS_IDLE;
            end
        endcase
        next_busy = (next_state != EPMS_IDLE);
        if (rst) begin
            next_state = EPMS_IDLE;
            next_cnt   = '0;
            next_rsp   = 1'b0;
            next_busy  = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        state     <= next_state;
        cnt       <= next_cnt;
        rsp_valid <= next_rsp;
        req_busy  <= next_busy;
    end

    // Strobes: low from the taking edge for STROBE_CYCLES cycles, never both
    always_comb begin
        next_wr_n = RST_STROBE_N;
        next_rd_n = RST_STROBE_N;
        case (state)
            EPMS_IDLE: begin
                if (take) begin
                    if (req_write) begin
                        next_wr_n = 1'b0;
                    end else begin
                        next_rd_n = 1'b0;
                    end
                end
            end
            EPMS_READ: begin
                next_rd_n = last_beat(cnt);
            end
            EPMS_WRITE: begin
                next_wr_n = last_beat(cnt);
            end
            default: begin
                next_wr_n = RST_STROBE_N;
                next_rd_n = RST_STROBE_N;
            end
        endcase
        if (rst) begin
            next_wr_n = RST_STROBE_N;
            next_rd_n = RST_STROBE_N;
        end
    end

    always_ff @(posedge clk) begin
        code_mem_write_strobe_n <= next_wr_n;
        code_mem_read_strobe_n  <= next_rd_n;
    end

    // Address and data: captured at the taking edge, held until the next access
    always_comb begin
        next_addr  = code_mem_addr;
        next_wdata = code_mem_data_out;
        next_rdata = rsp_rdata;
        next_oe    = code_mem_data_oe;
        case (state)
            EPMS_IDLE: begin
                next_oe = 1'b0;
                if (take) begin
                    next_addr  = req_addr;
                    next_wdata = req_wdata;
                    next_oe    = req_write;
                end
            end
            EPMS_READ: begin
                // Sampled while the read strobe is still low, so no hold is needed
                if (last_beat(cnt)) begin
                    next_rdata = code_mem_data_in;
                end
            end
            EPMS_WRITE: begin
                next_oe = 1'b1;                               // Bus driven through the strobe
            end
            EPMS_DONE: begin
                next_oe = 1'b0;
            end
            default: begin
                next_oe = 1'b0;
            end
        endcase
        if (rst) begin
            next_addr  = '0;
            next_wdata = '0;
            next_rdata = '0;
            next_oe    = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        code_mem_addr     <= next_addr;
        code_mem_data_out <= next_wdata;
        rsp_rdata         <= next_rdata;
        code_mem_data_oe  <= next_oe;
    end

    // Select: low through any access; released only from idle with no new request.
    // Release lags the power inputs by two cycles; a running access always finishes first.
    always_comb begin
        next_sel_n = release_ok && (state == EPMS_IDLE) && !take;
        if (rst) begin
            next_sel_n = RST_SELECT_N;
        end
    end

    always_ff @(posedge clk) begin
        code_mem_select_n <= next_sel_n;
    end
endmodule : epms_top

// ===== bench/epms_mem_model.sv
// Behavioural static code memory of 256 bytes for the strobe bench.
// Assumes active-low strobes and select, registered on clk.
`timescale 1ns/1ps
module epms_mem_model
    import epms_pkg::*;
(
    input  wire logic              clk,   // Core clock
    input  wire logic [ADDR_W-1:0] addr,  // Address pins
    input  wire logic [DATA_W-1:0] wdata, // Data from block
    input  wire logic              wr_n,  // Write strobe
    input  wire logic              rd_n,  // Read strobe
    input  wire logic              sel_n, // Chip select
    output logic      [DATA_W-1:0] rdata  // Data to block
);
    logic [DATA_W-1:0] mem [256];
    logic [DATA_W-1:0] last = 8'h00;
    // Released bus shows the inverse of the last value, so a stale copy never passes
    assign rdata = (!sel_n && !rd_n) ? mem[addr[7:0]] : ~last;
    // Only the low address byte is decoded; enough for the bench
    always @(posedge clk) begin
        if (!sel_n && !rd_n) last <= mem[addr[7:0]];
        if (!sel_n && !wr_n) mem[addr[7:0]] <= wdata;
    end
endmodule : epms_mem_model

// ===== bench/epms_checker.sv
// Checker of strobe, select and reset relations at the epms_top ports.
// Assumes one clock clk with synchronous active-high reset rst.
`timescale 1ns/1ps
module epms_checker
    import epms_pkg::*;
#(parameter int STROBE_CYCLES = STROBE_CYC)(
    input wire logic clk, rst, power_ctrl_bit0, wake_interrupt_two, sleep_select, // Inputs
    input wire logic req_valid, req_write, req_busy, rsp_valid, code_mem_data_oe, // Handshake
    input wire logic [ADDR_W-1:0] req_addr, code_mem_addr,                       // Addresses
    input wire logic code_mem_write_strobe_n, code_mem_read_strobe_n, code_mem_select_n
);
    logic gate, gate_q, take;
    // Sleep release condition, its one-cycle copy, and a request the block must accept
    assign gate = power_ctrl_bit0 && !wake_interrupt_two && sleep_select;
    always_ff @(posedge clk) gate_q <= gate && !rst;
    assign take = req_valid && !req_busy && !gate_q;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    AST_RD: assert property (take && !req_write |=> !code_mem_read_strobe_n
        ##STROBE_CYCLES code_mem_read_strobe_n && rsp_valid) else $error("read strobe timing");
    AST_WR: assert property (take && req_write |=> !code_mem_write_strobe_n
        ##STROBE_CYCLES code_mem_write_strobe_n && rsp_valid) else $error("write strobe timing");
    AST_ADDR: assert property (take |=> code_mem_addr == $past(req_addr))
        else $error("address not presented");
    AST_BOTH: assert property (code_mem_read_strobe_n || code_mem_write_strobe_n)
        else $error("both strobes low");
    AST_SEL: assert property (!(code_mem_read_strobe_n && code_mem_write_strobe_n)
        |-> !code_mem_select_n) else $error("strobe without select");
    AST_OE: assert property (!code_mem_write_strobe_n |-> code_mem_data_oe)
        else $error("write without data drive");
    AST_RST: assert property (disable iff (1'b0) rst |=> code_mem_select_n)
        else $error("select low after reset");
    AST_REL: assert property ($past(gate, 2) && $past(gate) && !$past(req_busy)
        && !$past(req_valid) && !$past(rst) && !$past(rst, 2) |-> code_mem_select_n)
        else $error("select not released");
    AST_WAKE: assert property (!$past(gate, 2) && !$past(gate) && !$past(rst)
        && !$past(rst, 2) |-> !code_mem_select_n) else $error("select not asserted");
endmodule : epms_checker
bind epms_top epms_checker #(.STROBE_CYCLES(STROBE_CYCLES)) u_chk (.clk, .rst,
    .power_ctrl_bit0, .wake_interrupt_two, .sleep_select, .req_valid, .req_write, .req_busy,
    .rsp_valid, .code_mem_data_oe, .req_addr, .code_mem_addr, .code_mem_write_strobe_n,
    .code_mem_read_strobe_n, .code_mem_select_n);

// ===== bench/test_ext_program_memory_strobes.sv
// Self-checking bench for the code memory strobe block with a static memory model.
// Assumes the default strobe width and a 20 MHz core clock.
`timescale 1ns/1ps
module test_ext_program_memory_strobes;
    import epms_pkg::*;
    logic clk = 0, rst = 1, idle = 0, wake = 0, slp = 0, rv = 0, rw = 0;
    logic [ADDR_W-1:0] ra = 16'h0000, ma;
    logic [DATA_W-1:0] wd = 8'h00, din, rd, dout;
    logic              busy, rsp, oe, wr_n, rd_n, sel_n;
    int                failures = 0, n_checks = 0;
    always #25 clk = ~clk;
    epms_top DUT (.clk, .rst, .power_ctrl_bit0(idle), .wake_interrupt_two(wake),
        .sleep_select(slp), .req_valid(rv), .req_write(rw), .req_addr(ra), .req_wdata(wd),
        .code_mem_data_in(din), .req_busy(busy), .rsp_valid(rsp), .rsp_rdata(rd),
        .code_mem_addr(ma), .code_mem_data_out(dout), .code_mem_data_oe(oe),
        .code_mem_write_strobe_n(wr_n), .code_mem_read_strobe_n(rd_n), .code_mem_select_n(sel_n));
    epms_mem_model mem (.clk, .addr(ma), .wdata(dout), .wr_n, .rd_n, .sel_n, .rdata(din));
    task automatic chk(input string what, input logic [15:0] exp, got);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // One access, judged on the pins and on the response
    task automatic access(input logic w, input logic [15:0] a, input logic [7:0] d);
        int n = 1;
        @(posedge clk) #1 {rv, rw, ra, wd} = {1'b1, w, a, d};
        @(posedge clk) #1 rv = 1'b0;
        chk("addr pins", a, ma);
        chk("strobes", {w, !w, 1'b0}, {rd_n, wr_n, sel_n});
        if (w) chk("write bus", {1'b1, d}, {oe, dout});
        while (rsp !== 1'b1 && n < 20) begin
            @(posedge clk) #1 n++;
        end
        chk("latency", STROBE_CYC + 1, n);
        chk("strobes off", 2'b11, {rd_n, wr_n});
        if (!w) chk("read data", d, rd);
    endtask : access
    // Back-to-back writes then reads at boundary addresses
    task automatic t_rw;
        logic [15:0] a [3] = '{16'hffff, 16'h0000, 16'h1234};
        for (int w = 1; w >= 0; w--) begin
            for (int i = 0; i < 3; i++) begin
                access(w[0], a[i], a[i][7:0] ^ 8'h3c);
            end
        end
        $display("test rw done");
    endtask : t_rw
    // Release needs all three conditions; dropping any one reselects
    task automatic t_sleep;
        {idle, wake, slp} = 3'b101;
        repeat (3) @(posedge clk) #1;
        chk("select released", 1'b1, sel_n);
        rv = 1'b1;
        @(posedge clk) #1 rv = 1'b0;
        chk("busy while released", 1'b0, busy);
        for (int i = 0; i < 3; i++) begin
            {idle, wake, slp} = 3'b101 ^ (3'b100 >> i);
            repeat (3) @(posedge clk) #1;
            chk("select asserted", 1'b0, sel_n);
            {idle, wake, slp} = 3'b101;
            repeat (3) @(posedge clk) #1;
            chk("select released again", 1'b1, sel_n);
        end
        {idle, wake, slp} = 3'b000;
        repeat (3) @(posedge clk) #1;
        $display("test sleep done");
    endtask : t_sleep
    // Mid-run reset while selected, then a read straight after release
    task automatic t_reset;
        rst = 1'b1;
        @(posedge clk) #1 chk("mid reset levels", 3'b111, {sel_n, rd_n, wr_n});
        rst = 1'b0;
        access(1'b0, 16'hffff, 8'hc3);
        $display("test reset done");
    endtask : t_reset
    task automatic stop_test;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : stop_test
    // Main sequence; a mid-run reset is taken while the select is low
    initial begin
        repeat (16) @(posedge clk) #1;
        chk("reset levels", 3'b111, {sel_n, rd_n, wr_n});
        rst = 1'b0;
        t_rw;
        t_sleep;
        t_reset;
        stop_test;
    end
    // Watchdog well beyond the 70 or so cycles the tests need
    initial begin
        #100000;
        failures++;
        stop_test;
    end
endmodule : test_ext_program_memory_strobes
